// file: rtl/tx_shift_buffer_pkg.sv
// Package for the transmit shift buffer: widths, reset pattern, timing, carrier types.
// Assumes a single 40 MHz system clock and a data-rate tick from a divider.
package tx_shift_buffer_pkg;

  localparam int          STAGE_W         = 8;
  localparam int          BUF_W           = 2 * STAGE_W;
  localparam logic [7:0]  PREAMBLE_BYTE   = 8'hAA;
  localparam int          CLK_HZ          = 40000000;
  localparam int          DATA_RATE_BPS   = 256000;
  localparam int          BIT_CYCLES      = (CLK_HZ / DATA_RATE_BPS < 1) ? 1
                                            : CLK_HZ / DATA_RATE_BPS;
  localparam int          FIFO_DEPTH      = 8;

  typedef struct packed {
    logic [STAGE_W-1:0] data;
  } tx_byte_t;

  typedef struct packed {
    logic bit_val;
    logic active;
  } tx_bit_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } tx_state_t;

endpackage

// file: rtl/tx_byte_fifo.sv
// Byte FIFO between the host write path and the shift buffer refill.
// Assumes one clock; storage in flip-flops addressed by an index.
`timescale 1ns/10ps
module tx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  always_comb begin
    push        = in_valid_i && (cnt_q != AW'(0) + (AW+1)'(DEPTH));
    pop         = out_valid_o && out_ready_i;
    in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    out_valid_o = (cnt_q != '0);
    out_data_o  = mem_q[rd_q];
    wr_d        = wr_q;
    rd_d        = rd_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule

// file: rtl/tx_shift_buffer.sv
// Transmit shift buffer: two chained byte stages feeding the modulator, MSB first.
// Assumes host bytes arrive already deserialised from SPI, synchronous to CLK_I.
// Functional notes
// - The buffer is one 16-bit shift register built from two chained 8-bit stages.
// - Reset loads both stages with AAh so the buffer can act as a preamble.
// - Disabling and re-enabling the transmitter keeps the buffer content as is.
// - Setting the transmitter enable starts shifting at once with no start command.
// - With no host data after reset the two AAh bytes go out, then zeros.
// - Refill readiness shows as serial data out high and the active-low interrupt low.
`timescale 1ns/10ps
module tx_shift_buffer
  import tx_shift_buffer_pkg::*;
#(
  parameter int BIT_DIV = BIT_CYCLES,
  parameter int DEPTH   = FIFO_DEPTH
) (
  input  wire logic               CLK_I,
  input  wire logic               SYS_RST_I,
  input  wire logic               TX_ENABLE_I,
  input  wire logic [STAGE_W-1:0] HOST_BYTE_I,
  input  wire logic               HOST_BYTE_VALID_I,
  output logic                    HOST_BYTE_READY_O,
  output logic                    TX_BIT_O,
  output logic                    TX_BIT_STROBE_O,
  output logic                    SDO_READY_O,
  output logic                    HOST_INTERRUPT_REQUEST_N_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Data-rate tick divider
  localparam int DW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;

  logic [DW-1:0] div_q, div_d;
  logic          tick;

  always_comb begin
    tick  = TX_ENABLE_I && (div_q == DW'(BIT_DIV - 1));
    div_d = div_q;
    if (!TX_ENABLE_I || tick) begin
      div_d = '0;
    end else begin
      div_d = div_q + DW'(1);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host byte FIFO; a mirrored fill count, not its ready, back-pressures the host write path
  localparam int OW = $clog2(DEPTH + 1);

  tx_byte_t      fifo_out;
  logic          fifo_valid, fifo_pop, push_acc;
  logic [OW-1:0] occ_q, occ_d;   // Mirror of the FIFO fill level

  tx_byte_fifo #(
    .WIDTH (STAGE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rst_i       (SYS_RST_I),
    .in_data_i   (HOST_BYTE_I),
    .in_valid_i  (push_acc),
    .in_ready_o  (),
    .out_data_o  (fifo_out.data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shift buffer and control
  tx_state_t          state_q, state_d;
  logic [STAGE_W-1:0] stage_hi_q, stage_hi_d;   // Shifts out first
  logic [STAGE_W-1:0] stage_lo_q, stage_lo_d;
  logic [3:0]         bitcnt_q, bitcnt_d;       // Bits left in the high stage
  logic               lo_full_q, lo_full_d;
  logic               refill_q, refill_d;
  tx_bit_t            out_q, out_d;
  logic               rdy_q, rdy_d;
  logic               irq_n_q, irq_n_d;
  logic [BUF_W-1:0]   merged;

  always_comb begin
    state_d    = state_q;
    stage_hi_d = stage_hi_q;
    stage_lo_d = stage_lo_q;
    bitcnt_d   = bitcnt_q;
    lo_full_d  = lo_full_q;
    refill_d   = refill_q;
    out_d      = out_q;
    out_d.active = 1'b0;
    fifo_pop   = 1'b0;
    // Late byte lands right behind the bits still left in the high stage
    merged     = {stage_hi_q, stage_lo_q} | ({fifo_out.data, {STAGE_W{1'b0}}} >> bitcnt_q);
    case (state_q)
      ST_IDLE: begin
        // Content is kept across disable; only reset restores AAh
        if (TX_ENABLE_I) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!TX_ENABLE_I) begin
          // Bits still held are dropped from view until re-enable
          state_d  = ST_IDLE;
          refill_d = 1'b0;
        end else if (tick) begin
          out_d.bit_val = stage_hi_q[STAGE_W-1];
          out_d.active  = 1'b1;
          stage_hi_d    = {stage_hi_q[STAGE_W-2:0], stage_lo_q[STAGE_W-1]};
          stage_lo_d    = {stage_lo_q[STAGE_W-2:0], 1'b0};
          if (bitcnt_q == 4'h1) begin
            bitcnt_d = 4'h8;
            if (fifo_valid) begin
              // A queued byte refills the vacated stage at once
              stage_lo_d = fifo_out.data;
              fifo_pop   = 1'b1;
              lo_full_d  = 1'b1;
              refill_d   = 1'b0;
            end else begin
              lo_full_d = 1'b0;
              refill_d  = 1'b1;
            end
          end else begin
            bitcnt_d = bitcnt_q - 4'h1;
          end
        end else if (!lo_full_q && fifo_valid) begin
          // Late byte: merge into the emptied bit positions
          stage_hi_d = merged[BUF_W-1:STAGE_W];
          stage_lo_d = merged[STAGE_W-1:0];
          fifo_pop   = 1'b1;
          lo_full_d  = 1'b1;
          refill_d   = 1'b0;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    push_acc = HOST_BYTE_VALID_I && rdy_q;
    occ_d    = occ_q + OW'(push_acc) - OW'(fifo_pop);
    // Ready looks one push ahead so a stale high never loses a byte
    rdy_d    = (occ_d != OW'(DEPTH));
    irq_n_d  = ~refill_d;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_q    <= ST_IDLE;
      stage_hi_q <= PREAMBLE_BYTE;
      stage_lo_q <= PREAMBLE_BYTE;
      bitcnt_q   <= 4'h8;
      lo_full_q  <= 1'b1;
      refill_q   <= 1'b0;
      out_q      <= '0;
      rdy_q      <= 1'b0;
      occ_q      <= '0;
      irq_n_q    <= 1'b1;
    end else begin
      state_q    <= state_d;
      stage_hi_q <= stage_hi_d;
      stage_lo_q <= stage_lo_d;
      bitcnt_q   <= bitcnt_d;
      lo_full_q  <= lo_full_d;
      refill_q   <= refill_d;
      out_q      <= out_d;
      rdy_q      <= rdy_d;
      occ_q      <= occ_d;
      irq_n_q    <= irq_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    TX_BIT_O                   = out_q.bit_val;
    TX_BIT_STROBE_O            = out_q.active;
    SDO_READY_O                = refill_q;
    HOST_INTERRUPT_REQUEST_N_O = irq_n_q;
    HOST_BYTE_READY_O          = rdy_q;
  end

endmodule

// file: verif/tx_shift_buffer_sva.sv
// Checker for the transmit shift buffer, bound to its top ports.
// Assumes BIT_DIV of 4, as the bench sets it.
`timescale 1ns/10ps
module tx_shift_buffer_chk #(
  parameter int BIT_DIV = 4
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic TX_ENABLE_I,
  input wire logic HOST_BYTE_VALID_I,
  input wire logic HOST_BYTE_READY_O,
  input wire logic TX_BIT_O,
  input wire logic TX_BIT_STROBE_O,
  input wire logic SDO_READY_O,
  input wire logic HOST_INTERRUPT_REQUEST_N_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  chk_irq_mirror: assert property (HOST_INTERRUPT_REQUEST_N_O == !SDO_READY_O)
    else $error("irq and sdo ready disagree");
  chk_ready_holds: assert property ((!HOST_BYTE_VALID_I [*3] ##0 (SDO_READY_O && TX_ENABLE_I))
    ##1 TX_ENABLE_I |-> SDO_READY_O)
    else $error("refill request dropped without a byte");
  chk_ready_clears: assert property (SDO_READY_O && TX_ENABLE_I && HOST_BYTE_VALID_I &&
    HOST_BYTE_READY_O |-> ##[1:5] !SDO_READY_O)
    else $error("refill request kept after a byte");
  chk_first_bit: assert property ($rose(TX_ENABLE_I) |-> ##[1:6] TX_BIT_STROBE_O)
    else $error("no bit after enable");
  chk_idle_quiet: assert property (!TX_ENABLE_I [*2] |-> !TX_BIT_STROBE_O)
    else $error("bit sent while disabled");
  chk_strobe_gap: assert property (TX_BIT_STROBE_O |=> !TX_BIT_STROBE_O [*3])
    else $error("bits too close");
  chk_strobe_period: assert property (TX_BIT_STROBE_O && TX_ENABLE_I ##1 TX_ENABLE_I [*3]
    |=> TX_BIT_STROBE_O)
    else $error("bit period wrong");
  chk_bit_steady: assert property (!TX_BIT_STROBE_O |-> $stable(TX_BIT_O))
    else $error("bit changed between strobes");
  cover property (SDO_READY_O && HOST_BYTE_VALID_I);
  cover property ($fell(TX_ENABLE_I));
  cover property (!HOST_BYTE_READY_O && HOST_BYTE_VALID_I);
endmodule
bind tx_shift_buffer tx_shift_buffer_chk #(.BIT_DIV(BIT_DIV)) u_chk (.CLK_I(CLK_I),
  .SYS_RST_I(SYS_RST_I), .TX_ENABLE_I(TX_ENABLE_I), .HOST_BYTE_VALID_I(HOST_BYTE_VALID_I),
  .HOST_BYTE_READY_O(HOST_BYTE_READY_O), .TX_BIT_O(TX_BIT_O),
  .TX_BIT_STROBE_O(TX_BIT_STROBE_O), .SDO_READY_O(SDO_READY_O),
  .HOST_INTERRUPT_REQUEST_N_O(HOST_INTERRUPT_REQUEST_N_O));

// file: verif/host_model.sv
// Host model: answers refill requests with a short script, or floods on demand.
// Assumes the buffer flags a wanted byte on sdo and the active-low interrupt.
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk_i,
  input  wire logic       irq_n_i,
  input  wire logic       sdo_i,
  input  wire logic       ready_i,
  input  wire logic       arm_i,
  input  wire logic       burst_i,
  output logic      [7:0] byte_o,
  output logic            valid_o
);
  logic [3:0] sent_q = 4'h0;
  logic       busy_q = 1'b0;
  initial valid_o = 1'b0;
  initial byte_o = 8'h00;
  // Released data shows the inverse so a stale byte is never mistaken
  // Refill request is the only interrupt source here, so no status read
  always @(posedge clk_i) begin
    if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      byte_o  <= ~byte_o;
      sent_q  <= sent_q + 4'h1;
    end else if (!valid_o && (burst_i || (arm_i && !busy_q && !irq_n_i && sdo_i
                 && sent_q < 4'h2))) begin
      valid_o <= 1'b1;
      busy_q  <= 1'b1;
      byte_o  <= burst_i ? 8'h80 + {4'h0, sent_q} : (sent_q == 4'h0 ? 8'hC5 : 8'h00);
    end else if (irq_n_i) begin
      busy_q <= 1'b0;
    end
  end
endmodule

// file: verif/tb_top.sv
// Bench for the transmit shift buffer with the host model on the byte side.
// Assumes BIT_DIV of 4, so one byte leaves in 32 clocks.
`timescale 1ns/10ps
module tb_top;
  logic        clk;
  logic        rst = 1'b1;
  logic        en = 1'b0;
  logic        arm = 1'b0;
  logic        burst = 1'b0;
  logic [7:0]  bdat;
  logic        bval, brdy, tbit, tstb, sdo, irq_n;
  logic [31:0] v;
  int          err_total = 0;
  int          n_tests = 0;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  tx_shift_buffer #(.BIT_DIV(4), .DEPTH(8)) uut (.CLK_I(clk), .SYS_RST_I(rst),
    .TX_ENABLE_I(en), .HOST_BYTE_I(bdat), .HOST_BYTE_VALID_I(bval), .HOST_BYTE_READY_O(brdy),
    .TX_BIT_O(tbit), .TX_BIT_STROBE_O(tstb), .SDO_READY_O(sdo),
    .HOST_INTERRUPT_REQUEST_N_O(irq_n));
  host_model host (.clk_i(clk), .irq_n_i(irq_n), .sdo_i(sdo), .ready_i(brdy), .arm_i(arm),
    .burst_i(burst), .byte_o(bdat), .valid_o(bval));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait per bit; a stall ends the run
  task automatic get_bits(int n, output logic [31:0] r);
    int t;
    r = 32'h0;
    for (int i = 0; i < n; i++) begin
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (tstb !== 1'b1 && t < 50);
      if (t >= 50) begin
        err_total++;
        complete_run();
      end
      r = {r[30:0], tbit};
    end
  endtask
  task automatic idle_check(int n);
    int s = 0;
    repeat (n) begin
      @(negedge clk);
      if (tstb !== 1'b0) s++;
    end
    check("strobes while idle", 32'h0, 32'(s));
  endtask
  task automatic test_reset();
    check("sdo ready", 32'h0, 32'(sdo));
    check("irq_n", 32'h1, 32'(irq_n));
    idle_check(20);
    $display("test reset done");
  endtask
  task automatic test_stream();
    arm = 1'b1;
    en = 1'b1;
    get_bits(32, v);
    check("stream", 32'hAAAAC500, v);
    check("sdo after last", 32'h1, 32'(sdo));
    check("irq_n after last", 32'h0, 32'(irq_n));
    en = 1'b0;
    $display("test stream done");
  endtask
  task automatic test_reenable();
    idle_check(10);
    en = 1'b1;
    get_bits(8, v);
    check("kept content", 32'h0, v);
    en = 1'b0;
    $display("test reenable done");
  endtask
  // Fill while disabled until refused, then drain in write order
  task automatic test_fill();
    int t = 0;
    burst = 1'b1;
    while (brdy !== 1'b0 && t < 60) begin
      @(negedge clk);
      t++;
    end
    burst = 1'b0;
    if (t >= 60) begin
      err_total++;
      complete_run();
    end
    check("fifo refuses when full", 32'h0, 32'(brdy));
    idle_check(6);
    en = 1'b1;
    get_bits(8, v);
    check("drain lead", 32'h0, v);
    for (int i = 0; i < 8; i++) begin
      get_bits(8, v);
      check("drain byte", 32'h82 + 32'(i), v);
    end
    $display("test fill done");
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    test_reset();
    test_stream();
    test_reenable();
    test_fill();
    complete_run();
  end
endmodule
